// file: inc/scrb_pkg.sv
// Constants shared by the synthesizer control register bank
package scrb_pkg;

   // ****************************************************
   // Serial frame layout
   // ****************************************************
   localparam int FRAME_BITS = 22;            // 18 data bits then 4 address
   localparam int DATA_BITS = 18;             // Data word width
   localparam int ADDR_BITS = 4;              // Register address width
   localparam int DATA_MSB = 21;              // Data sits in frame[21:4]
   localparam int DATA_LSB = 4;
   localparam int ADDR_MSB = 3;               // Address sits in frame[3:0]

   // ****************************************************
   // Register addresses
   // ****************************************************
   localparam logic [3:0] ADDR_MAIN_CONFIGURATION = 4'h0;
   localparam logic [3:0] ADDR_PHASE_DETECTOR_GAIN = 4'h1;
   localparam logic [3:0] ADDR_SECTION_POWER_CONTROL = 4'h2;
   localparam logic [3:0] ADDR_RF1_FEEDBACK_DIVIDER = 4'h3;
   localparam logic [3:0] ADDR_RF2_FEEDBACK_DIVIDER = 4'h4;
   localparam logic [3:0] ADDR_IF_FEEDBACK_DIVIDER = 4'h5;
   localparam logic [3:0] ADDR_RF1_REFERENCE_DIVIDER = 4'h6;
   localparam logic [3:0] ADDR_RF2_REFERENCE_DIVIDER = 4'h7;
   localparam logic [3:0] ADDR_IF_REFERENCE_DIVIDER = 4'h8;
   localparam logic [3:0] ADDR_RESERVED_LOW = 4'h9;
   localparam logic [3:0] ADDR_RESERVED_HIGH = 4'hf;

   // ****************************************************
   // Field positions
   // ****************************************************
   localparam int AUX_SEL_LSB = 12;           // Main config 13:12
   localparam int IF_DIV_LSB = 10;            // Main config 11:10
   localparam int LOW_BIAS_BIT = 5;           // Main config 5
   localparam int AUTO_PU_BIT = 3;            // Main config 3
   localparam int AUTO_GAIN_BIT = 2;          // Main config 2
   localparam int EXT_FREQ_BIT = 1;           // Main config 1
   localparam int IF_GAIN_LSB = 4;            // Gain register 5:4
   localparam int RF2_GAIN_LSB = 2;           // Gain register 3:2
   localparam int RF1_GAIN_LSB = 0;           // Gain register 1:0
   localparam int IF_ON_BIT = 1;              // Power control bit 1
   localparam int RF_ON_BIT = 0;              // Power control bit 0
   localparam int RF1_N_BITS = 18;
   localparam int RF2_N_BITS = 17;
   localparam int IF_N_BITS = 16;
   localparam int R_BITS = 13;

   // ****************************************************
   // Field encodings
   // ****************************************************
   localparam logic [1:0] AUX_FORCE_LOW = 2'h1;
   localparam logic [1:0] AUX_LOCK_DETECT = 2'h3;

   // ****************************************************
   // Gain thresholds on N: code steps at each bound
   // ****************************************************
   localparam logic [17:0] IF_GAIN_T1 = 18'h00800;   // 2048
   localparam logic [17:0] IF_GAIN_T2 = 18'h01000;   // 4096
   localparam logic [17:0] IF_GAIN_T3 = 18'h02000;   // 8192
   localparam logic [17:0] RF2_GAIN_T1 = 18'h01000;  // 4096
   localparam logic [17:0] RF2_GAIN_T2 = 18'h02000;  // 8192
   localparam logic [17:0] RF2_GAIN_T3 = 18'h04000;  // 16384
   localparam logic [17:0] RF1_GAIN_T1 = 18'h02000;  // 8192
   localparam logic [17:0] RF1_GAIN_T2 = 18'h04000;  // 16384
   localparam logic [17:0] RF1_GAIN_T3 = 18'h08000;  // 32768

   // ****************************************************
   // Reset values
   // ****************************************************
   localparam logic [1:0] RST_FIELD2 = 2'h0;
   localparam logic RST_BIT = 1'b0;
   localparam logic [17:0] RST_N = 18'h00000;
   localparam logic [12:0] RST_R = 13'h0000;
   localparam logic RST_AUX = 1'b0;           // Aux pin after reset
   // Pin synchroniser after reset: latch enable at its idle high level,
   // so reset release never looks like the end of a frame
   localparam logic [3:0] RST_PIN_SYNC = 4'h8;

endpackage

// file: src/scrb_sync.sv
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/10ps

module scrb_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0   // Idle level of each pin
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic [WIDTH-1:0] d_async,
   output logic [WIDTH-1:0] q_sync
);

   logic [WIDTH-1:0] meta_q;   // First stage, read only by second stage

   // ****************************************************
   // Two stages, both loaded with RST_VAL by reset
   // ****************************************************
   always_ff @(posedge clock) begin
      if (srst) begin
         meta_q <= RST_VAL;
         q_sync <= RST_VAL;
      end else begin
         meta_q <= d_async;
         q_sync <= meta_q;
      end
   end

endmodule // scrb_sync

// file: src/scrb_gain_map.sv
// Maps a feedback divider value to a phase detector gain code
`timescale 1ns/10ps

module scrb_gain_map #(
   parameter logic [17:0] T1 = 18'h00800,
   parameter logic [17:0] T2 = 18'h01000,
   parameter logic [17:0] T3 = 18'h02000
) (
   input wire logic [17:0] n_value,
   output logic [1:0] gain_code
);

   // ****************************************************
   // Larger N wants lower gain to keep the loop stable
   // ****************************************************
   always_comb begin
      if (n_value < T1) begin
         gain_code = 2'h0;
      end else if (n_value < T2) begin
         gain_code = 2'h1;
      end else if (n_value < T3) begin
         gain_code = 2'h2;
      end else begin
         gain_code = 2'h3;
      end
   end

endmodule // scrb_gain_map

// file: src/scrb_top.sv
// Control register bank of a triple-loop frequency synthesizer
`timescale 1ns/10ps

// What this block does
// - Aux select 01 drives low, 11 lock-detect
// - Lock detect flags imminent drift loss
// - Both sections flagging gives OR on aux
// - Powerdown pin low forces both sections off
// - Pin high, auto clear: register bits decide
// - Pin high, auto set: both sections on
// - Bit1 IF, bit0 RF; one means on
// - Writes accepted in every power state
// - IF output divider 1, 2, 4, 8
// - Bit 5 selects IF low bias
// - Bit 2 selects automatic gain from N
// - Gain codes full, half, quarter, eighth
// - IF gain thresholds 2048, 4096, 8192
// - RF2 gain thresholds 4096, 8192, 16384
// - RF1 gain thresholds 8192, 16384, 32768
// - Frame is 18 data bits, then 4-bit address

module scrb_top
   import scrb_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic link_sclk,
   input wire logic link_sdata,
   input wire logic link_sen_n,
   input wire logic power_down_pin_n,
   input wire logic if_drift_alarm,
   input wire logic rf_drift_alarm,
   output logic aux_output_pin,
   output logic if_section_on,
   output logic rf_section_on,
   output logic ref_amp_on,
   output logic [1:0] if_out_divider,
   output logic if_low_bias,
   output logic rf_extended_freq_ctrl,
   output logic [1:0] if_pd_gain,
   output logic [1:0] rf2_pd_gain,
   output logic [1:0] rf1_pd_gain,
   output logic [RF1_N_BITS-1:0] rf1_n_value,
   output logic [RF2_N_BITS-1:0] rf2_n_value,
   output logic [IF_N_BITS-1:0] if_n_value,
   output logic [R_BITS-1:0] rf1_r_value,
   output logic [R_BITS-1:0] rf2_r_value,
   output logic [R_BITS-1:0] if_r_value,
   output logic rf_vco_select
);

   // ****************************************************
   // Declarations
   // ****************************************************
   // Link side: shift register on the serial clock
   logic [FRAME_BITS-1:0] frame_q;

   // Synchronised pins and the latch-enable edge detector
   logic [3:0] pins_sync;          // Outputs of the synchroniser
   logic sen_sync;                 // Latch enable, synchronised
   logic pin_on_sync;              // Powerdown pin, high means run
   logic if_alarm_sync;            // IF drift alarm, synchronised
   logic rf_alarm_sync;            // RF drift alarm, synchronised
   logic sen_prev_q;               // Last sample of the latch enable
   logic latch_pulse;              // One cycle at end of a frame

   // Captured frame fields
   logic [ADDR_BITS-1:0] wr_addr;
   logic [DATA_BITS-1:0] wr_data;

   // Main configuration fields
   logic [1:0] aux_sel_q;
   logic auto_pu_q;
   logic auto_gain_q;

   // Manual gain fields
   logic [1:0] if_gain_q;
   logic [1:0] rf2_gain_q;
   logic [1:0] rf1_gain_q;

   // Software power bits
   logic if_on_q;
   logic rf_on_q;

   // Automatic gain codes from the divider values
   logic [1:0] if_auto_gain;
   logic [1:0] rf2_auto_gain;
   logic [1:0] rf1_auto_gain;

   // ****************************************************
   // Link domain: serial shift register
   // ****************************************************
   // Shifts on every rising serial clock edge, MSB first. The serial
   // clock may stop between frames, so nothing here relies on a reset
   // or on edges outside a frame; the frame's own latch enable ends it.
   always_ff @(posedge link_sclk) begin
      frame_q <= {frame_q[FRAME_BITS-2:0], link_sdata};
   end

   // ****************************************************
   // Pin synchronisers
   // ****************************************************
   // The four level pins pass two flops before any logic reads them; the flops
   // reset to the idle pin levels so no false latch edge follows reset
   scrb_sync #(
      .WIDTH(4),
      .RST_VAL(RST_PIN_SYNC)
   ) u_pin_sync (
      .clock(clock),
      .srst(srst),
      .d_async({link_sen_n, power_down_pin_n, if_drift_alarm,
                rf_drift_alarm}),
      .q_sync(pins_sync)
   );

   assign sen_sync = pins_sync[3];
   assign pin_on_sync = pins_sync[2];
   assign if_alarm_sync = pins_sync[1];
   assign rf_alarm_sync = pins_sync[0];

   // ****************************************************
   // Frame latch detection
   // ****************************************************
   // Starts high so that a latch enable already high at reset
   // release is not taken as a frame end
   always_ff @(posedge clock) begin
      if (srst) begin
         sen_prev_q <= 1'b1;
      end else begin
         sen_prev_q <= sen_sync;
      end
   end

   // Rising edge of the latch enable closes a frame. The shift
   // register is stable then because the serial clock is idle while
   // the latch enable is high, so the word crosses without a gray
   // code: the synchronised edge acts as the handshake.
   assign latch_pulse = sen_sync & ~sen_prev_q;
   assign wr_addr = frame_q[ADDR_MSB:0];
   assign wr_data = frame_q[DATA_MSB:DATA_LSB];

   // ****************************************************
   // Main configuration register
   // ****************************************************
   // Writes go through whatever the power state is
   always_ff @(posedge clock) begin
      if (srst) begin
         aux_sel_q <= RST_FIELD2;
         if_out_divider <= RST_FIELD2;
         if_low_bias <= RST_BIT;
         auto_pu_q <= RST_BIT;
         auto_gain_q <= RST_BIT;
         rf_extended_freq_ctrl <= RST_BIT;
      end else if (latch_pulse &&
                   wr_addr == ADDR_MAIN_CONFIGURATION) begin
         aux_sel_q <= wr_data[AUX_SEL_LSB+:2];
         if_out_divider <= wr_data[IF_DIV_LSB+:2];
         if_low_bias <= wr_data[LOW_BIAS_BIT];
         auto_pu_q <= wr_data[AUTO_PU_BIT];
         auto_gain_q <= wr_data[AUTO_GAIN_BIT];
         rf_extended_freq_ctrl <= wr_data[EXT_FREQ_BIT];
      end
   end

   // ****************************************************
   // Phase detector gain register
   // ****************************************************
   // Reserved bits are dropped; the host keeps them zero
   always_ff @(posedge clock) begin
      if (srst) begin
         if_gain_q <= RST_FIELD2;
         rf2_gain_q <= RST_FIELD2;
         rf1_gain_q <= RST_FIELD2;
      end else if (latch_pulse &&
                   wr_addr == ADDR_PHASE_DETECTOR_GAIN) begin
         if_gain_q <= wr_data[IF_GAIN_LSB+:2];
         rf2_gain_q <= wr_data[RF2_GAIN_LSB+:2];
         rf1_gain_q <= wr_data[RF1_GAIN_LSB+:2];
      end
   end

   // ****************************************************
   // Section power control register
   // ****************************************************
   // Held in flops that are never cleared by powerdown, so sections
   // come back with the last programmed settings
   always_ff @(posedge clock) begin
      if (srst) begin
         if_on_q <= RST_BIT;
         rf_on_q <= RST_BIT;
      end else if (latch_pulse &&
                   wr_addr == ADDR_SECTION_POWER_CONTROL) begin
         if_on_q <= wr_data[IF_ON_BIT];
         rf_on_q <= wr_data[RF_ON_BIT];
      end
   end

   // ****************************************************
   // Divider registers
   // ****************************************************
   // Each word but the RF1 N word, stored whole, keeps only its low bits; the rest are reserved.
   // The outputs are these flops themselves.
   always_ff @(posedge clock) begin
      if (srst) begin
         rf1_n_value <= RST_N;
         rf2_n_value <= RST_N[RF2_N_BITS-1:0];
         if_n_value <= RST_N[IF_N_BITS-1:0];
         rf1_r_value <= RST_R;
         rf2_r_value <= RST_R;
         if_r_value <= RST_R;
      end else if (latch_pulse) begin
         unique case (wr_addr)
            ADDR_RF1_FEEDBACK_DIVIDER: begin
               rf1_n_value <= wr_data[RF1_N_BITS-1:0];
            end
            ADDR_RF2_FEEDBACK_DIVIDER: begin
               rf2_n_value <= wr_data[RF2_N_BITS-1:0];
            end
            ADDR_IF_FEEDBACK_DIVIDER: begin
               if_n_value <= wr_data[IF_N_BITS-1:0];
            end
            ADDR_RF1_REFERENCE_DIVIDER: begin
               rf1_r_value <= wr_data[R_BITS-1:0];
            end
            ADDR_RF2_REFERENCE_DIVIDER: begin
               rf2_r_value <= wr_data[R_BITS-1:0];
            end
            ADDR_IF_REFERENCE_DIVIDER: begin
               if_r_value <= wr_data[R_BITS-1:0];
            end
            // Other registers and reserved 9 to 15 touch no divider,
            // which is a safe answer to a write the host must not make
            default: begin
            end
         endcase
      end
   end

   // ****************************************************
   // RF oscillator selection
   // ****************************************************
   // The last RF divider written, N or R, picks the RF output source
   always_ff @(posedge clock) begin
      if (srst) begin
         rf_vco_select <= RST_BIT;
      end else if (latch_pulse) begin
         if (wr_addr == ADDR_RF1_FEEDBACK_DIVIDER ||
             wr_addr == ADDR_RF1_REFERENCE_DIVIDER) begin
            rf_vco_select <= 1'b0;
         end else if (wr_addr == ADDR_RF2_FEEDBACK_DIVIDER ||
                      wr_addr == ADDR_RF2_REFERENCE_DIVIDER) begin
            rf_vco_select <= 1'b1;
         end
      end
   end

   // ****************************************************
   // Automatic gain mapping
   // ****************************************************
   // One comparator chain per loop, thresholds set per loop
   scrb_gain_map #(
      .T1(IF_GAIN_T1),
      .T2(IF_GAIN_T2),
      .T3(IF_GAIN_T3)
   ) u_if_gain (
      .n_value({2'h0, if_n_value}),
      .gain_code(if_auto_gain)
   );

   scrb_gain_map #(
      .T1(RF2_GAIN_T1),
      .T2(RF2_GAIN_T2),
      .T3(RF2_GAIN_T3)
   ) u_rf2_gain (
      .n_value({1'b0, rf2_n_value}),
      .gain_code(rf2_auto_gain)
   );

   scrb_gain_map #(
      .T1(RF1_GAIN_T1),
      .T2(RF1_GAIN_T2),
      .T3(RF1_GAIN_T3)
   ) u_rf1_gain (
      .n_value(rf1_n_value),
      .gain_code(rf1_auto_gain)
   );

   // ****************************************************
   // Gain outputs
   // ****************************************************
   // Automatic mode ignores the manual fields, so a host in that mode
   // may leave them unprogrammed. The code itself is the gain setting:
   // 0 full, 1 half, 2 quarter, 3 eighth.
   always_ff @(posedge clock) begin
      if (srst) begin
         if_pd_gain <= RST_FIELD2;
         rf2_pd_gain <= RST_FIELD2;
         rf1_pd_gain <= RST_FIELD2;
      end else if (auto_gain_q) begin
         if_pd_gain <= if_auto_gain;
         rf2_pd_gain <= rf2_auto_gain;
         rf1_pd_gain <= rf1_auto_gain;
      end else begin
         if_pd_gain <= if_gain_q;
         rf2_pd_gain <= rf2_gain_q;
         rf1_pd_gain <= rf1_gain_q;
      end
   end

   // ****************************************************
   // Power outputs
   // ****************************************************
   // The pin overrides everything; with the pin high the auto bit
   // stands in for both register bits. No configuration flop is
   // touched here, so sections wake with their last settings.
   always_ff @(posedge clock) begin
      if (srst) begin
         if_section_on <= RST_BIT;
         rf_section_on <= RST_BIT;
         ref_amp_on <= RST_BIT;
      end else if (!pin_on_sync) begin
         if_section_on <= 1'b0;
         rf_section_on <= 1'b0;
         ref_amp_on <= 1'b0;
      end else if (auto_pu_q) begin
         if_section_on <= 1'b1;
         rf_section_on <= 1'b1;
         ref_amp_on <= 1'b1;
      end else begin
         if_section_on <= if_on_q;
         rf_section_on <= rf_on_q;
         // Reference amplifier runs while either loop needs it
         ref_amp_on <= if_on_q | rf_on_q;
      end
   end

   // ****************************************************
   // Auxiliary output
   // ****************************************************
   // Lock detect is active low: either alarm pulls the pin low, so
   // simultaneous alarms read as their OR. Reserved codes drive low.
   always_ff @(posedge clock) begin
      if (srst) begin
         aux_output_pin <= RST_AUX;
      end else begin
         unique case (aux_sel_q)
            AUX_FORCE_LOW: begin
               aux_output_pin <= 1'b0;
            end
            AUX_LOCK_DETECT: begin
               aux_output_pin <=
                  ~(if_alarm_sync | rf_alarm_sync);
            end
            default: begin
               aux_output_pin <= 1'b0;
            end
         endcase
      end
   end

endmodule // scrb_top

// file: sim/scrb_sva.sv
// Port checks for the synthesizer control register bank
`timescale 1ns/10ps

module scrb_sva
   import scrb_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic link_sen_n,
   input wire logic power_down_pin_n,
   input wire logic if_drift_alarm,
   input wire logic rf_drift_alarm,
   input wire logic aux_output_pin,
   input wire logic if_section_on,
   input wire logic rf_section_on,
   input wire logic ref_amp_on,
   input wire logic [1:0] if_out_divider,
   input wire logic if_low_bias,
   input wire logic [1:0] if_pd_gain,
   input wire logic [1:0] rf1_pd_gain,
   input wire logic [RF1_N_BITS-1:0] rf1_n_value
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   // Link idle long enough for any latched write to have landed
   sequence s_quiet;
      link_sen_n [*8];
   endsequence
   // Five samples cover the sync stages plus one for phase
   a_pin_forces_off: assert property (!power_down_pin_n [*5] |->
      !if_section_on && !rf_section_on) else $error("section on, pin low");
   a_alarm_pulls_aux: assert property (
      (if_drift_alarm || rf_drift_alarm) [*5] |-> !aux_output_pin)
      else $error("aux high during alarm");
   a_ref_amp_or: assert property (
      ref_amp_on == (if_section_on || rf_section_on))
      else $error("reference amp mismatch");
   a_cfg_holds: assert property (
      s_quiet |-> $stable({if_out_divider, if_low_bias}))
      else $error("config moved without write");
   a_gain_holds: assert property (
      s_quiet |-> $stable({if_pd_gain, rf1_pd_gain}))
      else $error("gain moved without write");
   a_div_holds: assert property (
      s_quiet |-> $stable(rf1_n_value)) else $error("divider moved");
   a_power_holds: assert property (
      (link_sen_n && power_down_pin_n) [*8] |->
      $stable({if_section_on, rf_section_on})) else $error("power moved");
   a_aux_holds: assert property (
      (link_sen_n && !if_drift_alarm && !rf_drift_alarm) [*8] |->
      $stable(aux_output_pin)) else $error("aux moved without cause");
endmodule // scrb_sva

bind scrb_top scrb_sva u_sva (.clock, .srst, .link_sen_n,
   .power_down_pin_n, .if_drift_alarm, .rf_drift_alarm, .aux_output_pin,
   .if_section_on, .rf_section_on, .ref_amp_on, .if_out_divider,
   .if_low_bias, .if_pd_gain, .rf1_pd_gain, .rf1_n_value);

// file: sim/scrb_host.sv
// Host controller model driving the serial control link
`timescale 1ns/10ps

module scrb_host (
   output logic link_sclk,
   output logic link_sdata,
   output logic link_sen_n
);
   // Link rests with clock still and enable high
   initial begin
      link_sclk = 1'b0;
      link_sdata = 1'b0;
      link_sen_n = 1'b1;
   end
   // One frame, data then address, MSB first, 64 ns bit period
   task automatic send(input logic [21:0] frame);
      link_sen_n = 1'b0;
      for (int i = 21; i >= 0; i--) begin
         link_sdata = frame[i];
         #16 link_sclk = 1'b1;
         #32 link_sclk = 1'b0;
         #16;
      end
      #32 link_sen_n = 1'b1;
      // Released line flips so a stale level is never trusted
      link_sdata = ~link_sdata;
   endtask
endmodule // scrb_host

// file: sim/testbench.sv
// Self-checking bench for the control register bank
`timescale 1ns/10ps

module testbench;
   import scrb_pkg::*;
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
   $display("ERROR %0t got %h want %h", $time, a, e); end end
   logic clock, srst, power_down_pin_n, if_drift_alarm, rf_drift_alarm;
   wire link_sclk, link_sdata, link_sen_n;
   logic aux_output_pin, if_section_on, rf_section_on, ref_amp_on;
   logic if_low_bias, rf_extended_freq_ctrl, rf_vco_select;
   logic [1:0] if_out_divider, if_pd_gain, rf2_pd_gain, rf1_pd_gain;
   logic [RF1_N_BITS-1:0] rf1_n_value;
   logic [RF2_N_BITS-1:0] rf2_n_value;
   logic [IF_N_BITS-1:0] if_n_value;
   logic [R_BITS-1:0] rf1_r_value, rf2_r_value, if_r_value;
   int mismatches, n_tests, cycles;
   int nv[8] = '{2047, 2048, 4096, 8191, 8192, 16384, 32767, 32768};
   scrb_top DUT (.clock, .srst, .link_sclk, .link_sdata, .link_sen_n,
      .power_down_pin_n, .if_drift_alarm, .rf_drift_alarm, .aux_output_pin,
      .if_section_on, .rf_section_on, .ref_amp_on, .if_out_divider,
      .if_low_bias, .rf_extended_freq_ctrl, .if_pd_gain, .rf2_pd_gain,
      .rf1_pd_gain, .rf1_n_value, .rf2_n_value, .if_n_value, .rf1_r_value,
      .rf2_r_value, .if_r_value, .rf_vco_select);
   scrb_host host (.link_sclk, .link_sdata, .link_sen_n);
   // Gain code from N: steps at t, 2t and 4t
   function automatic logic [1:0] g(int n, int t);
      return n < t ? 2'h0 : n < 2 * t ? 2'h1 : n < 4 * t ? 2'h2 : 2'h3;
   endfunction
   // One register write, then room for the four-edge answer
   task automatic wr(input logic [3:0] a, input logic [17:0] d);
      host.send({d, a});
      repeat (8) @(posedge clock);
      #1;
   endtask
   // Pin and alarm levels, settled past the synchronisers
   task automatic pins(input logic p, input logic i, input logic r);
      power_down_pin_n = p;
      if_drift_alarm = i;
      rf_drift_alarm = r;
      repeat (6) @(posedge clock);
      #1;
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Whole run needs about 6900 cycles; a hang stops at the ceiling
   always @(posedge clock) begin
      cycles++;
      if (cycles == 30000) begin
         mismatches++;
         report_and_stop();
      end
   end
   initial begin
      srst = 1'b1;
      power_down_pin_n = 1'b1;
      if_drift_alarm = 1'b0;
      rf_drift_alarm = 1'b0;
      repeat (6) @(posedge clock);
      #1 srst = 1'b0;
      repeat (4) @(posedge clock);
      #1;
      `CHK({aux_output_pin, if_section_on, ref_amp_on}, 3'h0)
      for (int i = 0; i < 4; i++) begin
         wr(4'h0, 18'(i) << 10 | 18'(i % 2) << 5);
         `CHK(if_out_divider, 2'(i))
         `CHK(if_low_bias, 1'(i % 2))
         `CHK(rf_extended_freq_ctrl, 1'b0)
      end
      $display("test config done");
      wr(4'h0, 18'h03000);
      for (int j = 0; j < 4; j++) begin
         pins(1'b1, 1'(j / 2), 1'(j % 2));
         `CHK(aux_output_pin, 1'(j == 0))
      end
      wr(4'h0, 18'h01000);
      `CHK(aux_output_pin, 1'b0)
      $display("test aux done");
      wr(4'h0, 18'h00800);
      pins(1'b0, 1'b0, 1'b0);
      wr(4'h2, 18'h00003);
      `CHK({if_section_on, rf_section_on}, 2'h0)
      pins(1'b1, 1'b0, 1'b0);
      for (int k = 3; k >= 0; k--) begin
         wr(4'h2, 18'(k));
         `CHK({if_section_on, rf_section_on}, 2'(k))
         `CHK(ref_amp_on, 1'(k != 0))
      end
      wr(4'h0, 18'h00808);
      `CHK({if_section_on, rf_section_on}, 2'h3)
      pins(1'b0, 1'b0, 1'b0);
      pins(1'b1, 1'b0, 1'b0);
      `CHK({if_out_divider, if_section_on}, 3'h5)
      $display("test power done");
      wr(4'h0, 18'h00000);
      wr(4'h1, 18'h0001b);
      `CHK({if_pd_gain, rf2_pd_gain, rf1_pd_gain}, 6'h1b)
      wr(4'h0, 18'h00004);
      foreach (nv[m]) begin
         wr(4'h3, 18'(nv[m]));
         wr(4'h4, 18'(nv[m]));
         wr(4'h5, 18'(nv[m]));
         `CHK(rf1_pd_gain, g(nv[m], 8192))
         `CHK(rf2_pd_gain, g(nv[m], 4096))
         `CHK(if_pd_gain, g(nv[m], 2048))
         `CHK(if_n_value, 16'(nv[m]))
      end
      `CHK({rf_vco_select, rf2_n_value}, {1'b1, 17'h08000})
      $display("test gain done");
      wr(4'h9, 18'h3ffff);
      wr(4'hf, 18'h3ffff);
      `CHK({if_out_divider, rf1_n_value}, 20'h08000)
      wr(4'h6, 18'h01abc);
      `CHK(rf1_r_value, 13'h1abc)
      `CHK(rf_vco_select, 1'b0)
      wr(4'h7, 18'h00123);
      `CHK({rf_vco_select, rf2_r_value}, {1'b1, 13'h0123})
      wr(4'h8, 18'h00456);
      `CHK({rf_vco_select, if_r_value}, {1'b1, 13'h0456})
      $display("test address done");
      report_and_stop();
   end
endmodule // testbench
